// file: dv/udc_dma_model.sv
/* Behavioural external DMA controller.
   Assumes a level request; strobes last several sys_clk cycles. */
`timescale 1ns/1ps
module udc_dma_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Mode
  input wire logic ackOnly,
  input wire logic dirIn,
  input wire logic [2:0] hold,
  // DMA pins
  input wire logic devDmaRequest,
  output logic devDmaAcknowledgeN,
  output logic ioRdN,
  output logic ioWrN,
  output logic [15:0] dmaBusIn
);
  logic busy;
  logic [4:0] cnt;
  logic [15:0] word;
  // Long gap after release: a request about to drop is not taken for a new one
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {devDmaAcknowledgeN, ioRdN, ioWrN} <= 3'h7;
      busy <= 1'b0;
      cnt <= 5'h00;
      word <= 16'h1000;
      dmaBusIn <= 16'h0000;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end else if (busy) begin
      {devDmaAcknowledgeN, ioRdN, ioWrN} <= 3'h7;
      busy <= 1'b0;
      word <= word + 16'h0001;
      cnt <= 5'h07 + {2'h0, hold};
    end else if (devDmaRequest) begin
      devDmaAcknowledgeN <= 1'b0;
      ioRdN <= ackOnly | dirIn;
      ioWrN <= ackOnly | !dirIn;
      dmaBusIn <= word;
      busy <= 1'b1;
      cnt <= 5'h03 + {2'h0, hold};
    end else begin
      dmaBusIn <= ~dmaBusIn;
    end
  end
endmodule

// file: dv/udc_dma_port_chk.sv
/* Port assertions for udc_dma_port.
   Assumes it is bound into the design top; one clock domain. */
`timescale 1ns/1ps
module udc_dma_port_chk #(
  parameter int BURST_WORDS = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic commandSelectLine,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  input wire logic [7:0] cmdCode,
  input wire logic cmdExec,
  // DMA side
  input wire logic devDmaAcknowledgeN,
  input wire logic devDmaRequest,
  input wire logic dmaBusOe,
  input wire logic dmaDirIn,
  input wire logic epDiscard,
  input wire logic epSendNow,
  input wire logic dmaBusy,
  input wire logic dmaEndEvent
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire noData = !(regWrData[7:0] inside {[8'h20:8'h3F], 8'hBA, 8'hBB, [8'hF0:8'hF3]});

  a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data outside its cycle");
  a_cmd_exec_now: assert property (regWr && commandSelectLine && noData
    |=> cmdExec && cmdCode == $past(regWrData[7:0])) else $error("command not run");
  a_exec_has_cause: assert property (cmdExec |-> $past(regWr && commandSelectLine))
    else $error("command pulse without write");
  a_req_end_hold: assert property (dmaEndEvent |=> !devDmaRequest [*8])
    else $error("request after end");
  a_req_needs_run: assert property (devDmaRequest |-> dmaBusy)
    else $error("request while stopped");
  // Strobe passes two sync stages, so the pin is looked at two edges back
  a_oe_ack_out: assert property (dmaBusOe |-> !dmaDirIn && !$past(devDmaAcknowledgeN, 2))
    else $error("bus driven without ack");
  a_discard_out: assert property (epDiscard |-> !dmaDirIn && !dmaBusy)
    else $error("discard on IN");
  a_send_in: assert property (epSendNow |-> dmaDirIn && !dmaBusy)
    else $error("send on OUT");
endmodule

bind udc_dma_port udc_dma_port_chk #(.BURST_WORDS(BURST_WORDS)) u_chk (
  .sys_clk, .sys_rst, .commandSelectLine, .regWrData, .regWr, .regRd, .regRdData, .cmdCode,
  .cmdExec, .devDmaAcknowledgeN, .devDmaRequest, .dmaBusOe, .dmaDirIn, .epDiscard,
  .epSendNow, .dmaBusy, .dmaEndEvent
);

// file: dv/usb_device_dma_and_command_port_tb.sv
/* Self-checking bench for udc_dma_port with a DMA controller model.
   Assumes 200 MHz sys_clk and a one-cycle register port. */
`timescale 1ns/1ps
module usb_device_dma_and_command_port_tb;
  localparam int BW = 4;
  logic sys_clk = 1'b0, sys_rst = 1'b1, commandSelectLine = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic transferEndInput = 1'b0, epDataReady = 1'b1, epShortRx = 1'b0, epBufPartial = 1'b0;
  logic usbEndOfPacket = 1'b0, ackOnly = 1'b0, mDir = 1'b0, chkData = 1'b0, reqPrev = 1'b0;
  logic [15:0] regWrData = 16'h0000, epRdWord = 16'h0000, rnd, lenAtSend;
  logic [2:0] hold = 3'h0;
  logic oePrev = 1'b0;
  logic [15:0] rdPrev = 16'h0000, outExp = 16'h0000;
  logic [1:0] lastEn, epv [16];
  logic [15:0] regRdData, dmaBusIn, dmaBusOut, epWrWord, pktByteCount;
  logic devDmaAcknowledgeN, ioRdN, ioWrN, devDmaRequest, dmaBusOe, dmaDirIn, epRdTake;
  logic epWrPush, epDiscard, epSendNow, dmaBusy, dmaEndEvent, cmdExec;
  logic [3:0] dmaEndpoint;
  logic [1:0] epWrByteEn;
  logic [7:0] cmdCode;
  int nWords, nFalls, nEnd, nDisc, nSend, bad_count = 0, n_checks = 0, r;

  always #2.5 sys_clk = ~sys_clk;
  udc_dma_port #(.BURST_WORDS(BW)) dut (.sys_clk, .sys_rst, .commandSelectLine, .regWrData,
    .regWr, .regRd, .regRdData, .devDmaAcknowledgeN, .ioRdN, .ioWrN, .transferEndInput,
    .dmaBusIn, .devDmaRequest, .dmaBusOut, .dmaBusOe, .dmaEndpoint, .dmaDirIn, .epDataReady,
    .epRdWord, .epRdTake, .epWrWord, .epWrByteEn, .epWrPush, .pktByteCount, .epShortRx,
    .epBufPartial, .usbEndOfPacket, .epDiscard, .epSendNow, .dmaBusy, .dmaEndEvent, .cmdCode,
    .cmdExec);
  udc_dma_model model (.sys_clk, .sys_rst, .ackOnly, .dirIn(mDir), .hold, .devDmaRequest,
    .devDmaAcknowledgeN, .ioRdN, .ioWrN, .dmaBusIn);

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic sel, input logic [15:0] d);
    @(posedge sys_clk);
    commandSelectLine <= sel;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic op(input logic [7:0] c);
    wr(1'b1, {8'($urandom), c});
  endtask
  task automatic setReg(input logic [7:0] c, input logic [15:0] d);
    op(c);
    wr(1'b0, d);
  endtask
  task automatic rdChk(input logic [15:0] e, input string m);
    @(posedge sys_clk);
    commandSelectLine <= 1'b0;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData === e, m);
  endtask
  task automatic waitCnt(input logic useEnd, input int k, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if ((useEnd ? nEnd : nWords) >= k) break;
      @(posedge sys_clk);
    end
    if (i == lim) begin
      chk(1'b0, "wait limit");
      print_verdict();
    end
  endtask
  task automatic startDma(input logic [15:0] hw, input logic [3:0] ep, input logic [1:0] v,
                          input logic [15:0] cnt, input logic [3:0] fl);
    setReg(udc_pkg::CMD_HWCFG_WR, hw);
    setReg(udc_pkg::CMD_EPCFG_WR + {4'h0, ep}, {14'h0000, v});
    setReg(udc_pkg::CMD_DMACNT_WR, cnt);
    ackOnly <= hw[udc_pkg::HW_ACK_ONLY_BIT];
    mDir <= v[0];
    hold <= 3'($urandom);
    {nWords, nFalls, nEnd, nDisc, nSend} = '0;
    setReg(udc_pkg::CMD_DMACFG_WR, {8'h00, ep, fl});
    #1;
    chk(dmaEndpoint === ep && dmaDirIn === v[0], "ep select");
  endtask

  // Outputs are sampled mid-cycle where they have settled
  always @(negedge sys_clk) begin
    if (epWrPush && chkData) chk(epWrWord === 16'h1000 + 16'(nWords), "push data");
    if (epWrPush || epRdTake) begin
      nWords++;
      lastEn = epWrByteEn;
    end
    // OUT word is the buffer head seen just before the strobe began
    if (dmaBusOe && !oePrev) outExp = rdPrev;
    if (dmaBusOe) chk(dmaBusOut[7:0] === outExp[7:0], "out low byte");
    if (dmaBusOe) chk(dmaBusOut[15:8] === outExp[15:8], "out high byte");
    oePrev = dmaBusOe;
    rdPrev = epRdWord;
    if (reqPrev && !devDmaRequest) nFalls++;
    reqPrev = devDmaRequest;
    if (dmaEndEvent) nEnd++;
    if (epDiscard) nDisc++;
    if (epSendNow) begin
      nSend++;
      lenAtSend = pktByteCount;
    end
  end
  always @(posedge sys_clk) epRdWord <= 16'($urandom);

  initial begin
    void'($urandom(32'h56f1));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(devDmaRequest === 1'b0 && regRdData === 16'h0000, "reset");
    for (int i = 0; i < 16; i++) begin
      epv[i] = 2'($urandom);
      setReg(udc_pkg::CMD_EPCFG_WR + 8'(i), {14'h0000, epv[i]});
    end
    for (int i = 0; i < 16; i++) begin
      op(udc_pkg::CMD_EPCFG_RD + 8'(i));
      rdChk({14'h0000, epv[i]}, "ep cfg");
    end
    rnd = 16'($urandom);
    setReg(udc_pkg::CMD_DMACNT_WR, rnd);
    op(udc_pkg::CMD_DMACNT_RD);
    rdChk(rnd, "count");
    op(8'h50);
    rdChk(16'h0000, "unmapped");
    op(8'h70);
    #1;
    chk(cmdCode === 8'h70, "cmd code");
    // Odd count into IN endpoint, ack-only, single words
    r = 1 + $urandom % 4;
    chkData = 1'b1;
    epBufPartial <= 1'b1;
    startDma(16'h0100, 4'h1, 2'b01, 16'(2 * r + 1), 4'b0011);
    waitCnt(1'b1, 1, 2000);
    repeat (30) @(posedge sys_clk);
    chk(nWords == r + 1 && lastEn === 2'b01, "odd tail");
    chk(nFalls == r + 1 && lenAtSend === 16'(2 * r + 1), "req/len");
    chk(nSend == 1 && devDmaRequest === 1'b0, "send");
    chkData = 1'b0;
    // Fly-by OUT burst, two bursts
    startDma(16'h0000, 4'h2, 2'b00, 16'(4 * BW), 4'b1011);
    waitCnt(1'b1, 1, 4000);
    repeat (30) @(posedge sys_clk);
    chk(nWords == 2 * BW && nFalls == 2, "burst");
    for (int d = 0; d < 2; d++) begin
      startDma(16'h0100, 4'h3, 2'(d), 16'hFFFE, 4'b0001);
      waitCnt(1'b0, 2, 2000);
      transferEndInput <= 1'b1;
      repeat (4) @(posedge sys_clk);
      transferEndInput <= 1'b0;
      waitCnt(1'b1, 1, 100);
      repeat (30) @(posedge sys_clk);
      chk(nDisc == 1 - d && nSend == d && devDmaRequest === 1'b0, "end in");
    end
    startDma(16'h0100, 4'h4, 2'b01, 16'h0002, 4'b0001);
    waitCnt(1'b0, 3, 2000);
    setReg(udc_pkg::CMD_DMACFG_WR, 16'h0040);
    repeat (30) @(posedge sys_clk);
    chk(nEnd == 0 && dmaBusy === 1'b0 && devDmaRequest === 1'b0, "disable");
    startDma(16'h0000, 4'h5, 2'b00, 16'hFFFE, 4'b0101);
    waitCnt(1'b0, 2, 4000);
    epShortRx <= 1'b1;
    @(posedge sys_clk);
    epShortRx <= 1'b0;
    waitCnt(1'b0, nWords + 1, 2000);
    chk(nEnd == 0, "short early");
    epDataReady <= 1'b0;
    waitCnt(1'b1, 1, 200);
    epDataReady <= 1'b1;
    startDma(16'h0100, 4'h6, 2'b10, 16'hFFFE, 4'b0001);
    waitCnt(1'b0, 1, 2000);
    usbEndOfPacket <= 1'b1;
    @(posedge sys_clk);
    usbEndOfPacket <= 1'b0;
    waitCnt(1'b1, 1, 100);
    chk(nEnd == 1, "eop");
    print_verdict();
  end
endmodule

// file: rtl/udc_dma_port.sv
/*
  Device-controller DMA engine with the 16-bit command/data port.
  Assumes the register port runs on sys_clk; DMA pins and the DMA data bus
  are asynchronous and pass a two-stage synchroniser first.
*/
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// [RL1] Acknowledge-only protocol whenever ack_only_select in hardware_config is one.
// [RL2] Acknowledge-only: acknowledge is the data strobe, read/write strobes ignored.
// [RL3] Bulk DMA stops on end input, counter done, OUT short packet, or enable cleared.
// [RL4] End input during OUT read stops DMA and discards active buffer data only.
// [RL5] End input during IN write stops DMA and sends the partial packet.
// [RL6] 16-bit byte count loads on enable set; reaching count ends and stops DMA.
// [RL7] Counter completion ends transfer only with counter_stop_enable set.
// [RL8] Short packet stop: transfer the short packet's bytes first, then stop.
// [RL9] IN bulk short end when counter hits zero with buffer partly filled.
// [RL10] Clearing dma_enable_bit stops DMA with no end event.
// [RL11] Iso DMA stops on end input, counter done, USB end-of-packet, or enable cleared.
// [RL12] Software ends iso OUT by end-of-packet, iso IN by end input or counter.
// [RL13] Write with select line high takes low byte as command; no-data commands run at once.
// [RL14] Select line low moves data to/from selected register, low word first.
// [RL15] Port is 16 bits; upper byte ignored in command phase.
// [RL16] Processor uses only whole aligned 16-bit register accesses.
// [RL17] Odd IN length: upper byte of final word is not sent.
// [RL18] Firmware discards upper byte of final word of odd OUT packet.
// [RL19] Buffer carries packet length in its first two bytes before payload.
// [RL20] Endpoint config writes 20..2F, reads 30..3F, one word each.
// [RL21] Acknowledge-only clear: fly-by, read/write strobes qualify data during acknowledge.
// [RL22] Request drops after each word in single mode, after burst in burst mode.
// [RL23] Each 16-bit DMA word decrements the byte count by two.
// [RL24] After any end condition, no request until DMA is enabled again.
// [RL25] Controller asserts acknowledge only while requested or mid-burst.
module udc_dma_port #(
  parameter int BURST_WORDS = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic commandSelectLine,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // DMA pins
  input wire logic devDmaAcknowledgeN,
  input wire logic ioRdN,
  input wire logic ioWrN,
  input wire logic transferEndInput,
  input wire logic [15:0] dmaBusIn,
  output logic devDmaRequest,
  output logic [15:0] dmaBusOut,
  output logic dmaBusOe,
  // Endpoint buffer side
  output logic [3:0] dmaEndpoint,
  output logic dmaDirIn,
  input wire logic epDataReady,
  input wire logic [15:0] epRdWord,
  output logic epRdTake,
  output logic [15:0] epWrWord,
  output logic [1:0] epWrByteEn,
  output logic epWrPush,
  output logic [15:0] pktByteCount,
  input wire logic epShortRx,
  input wire logic epBufPartial,
  input wire logic usbEndOfPacket,
  output logic epDiscard,
  output logic epSendNow,
  // Status and commands
  output logic dmaBusy,
  output logic dmaEndEvent,
  output logic [7:0] cmdCode,
  output logic cmdExec
);

  localparam logic [3:0] LAST_BURST = 4'(BURST_WORDS - 1);

  typedef struct packed {
    udc_pkg::udc_state_t state;
    logic [15:0] hwCfg;
    logic [15:0] dmaCfg;
    logic [15:0] dmaCount;
    logic [15:0] byteCnt;
    logic [udc_pkg::NUM_EP-1:0][15:0] epCfg;
    logic [7:0] cmd;
    logic [15:0] rdData;
    logic [15:0] busOut;
    logic [15:0] capData;
    logic [15:0] wrWord;
    logic [1:0] wrByteEn;
    logic [15:0] pktBytes;
    logic [3:0] burstIdx;
    logic gap;
    logic prevStrobe;
    logic prevEnd;
    logic shortPend;
    logic rdTake;
    logic push;
    logic discard;
    logic sendNow;
    logic endEvt;
    logic exec;
  } udc_regs_t;

  udc_regs_t r_reg;
  udc_regs_t r_next;

  logic ackSync;
  logic rdSync;
  logic wrSync;
  logic endSync;
  logic [15:0] busSync;

  udc_sync #(
    .WIDTH(20),
    .INIT(20'h0_0000)
  ) pinSync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .asyncIn({~devDmaAcknowledgeN, ~ioRdN, ~ioWrN, transferEndInput, dmaBusIn}),
    .syncOut({ackSync, rdSync, wrSync, endSync, busSync})
  );

  function automatic logic inGroup(input logic [7:0] code, input logic [7:0] base);
    inGroup = (code[7:4] == base[7:4]);
  endfunction

  logic ackOnly;
  logic [3:0] epIdx;
  logic dirIn;
  logic isIso;
  logic strobeActive;
  logic wordEnd;
  logic [15:0] cntAfter;

  assign ackOnly = r_reg.hwCfg[udc_pkg::HW_ACK_ONLY_BIT];
  assign epIdx = r_reg.dmaCfg[udc_pkg::DMACFG_EP_LSB +: 4];
  assign dirIn = r_reg.epCfg[epIdx][udc_pkg::EPCFG_DIR_IN_BIT];
  assign isIso = r_reg.epCfg[epIdx][udc_pkg::EPCFG_ISO_BIT];
  // Acknowledge alone strobes in one mode, read/write strobes in the other
  assign strobeActive = ackOnly ? ackSync : // [RL1] [RL2]
                        (ackSync & (dirIn ? wrSync : rdSync)); // [RL21]
  assign wordEnd = r_reg.prevStrobe & ~strobeActive & (r_reg.state == udc_pkg::ST_RUN);
  // Saturate so an odd count ends at zero, not wrapping
  assign cntAfter = (r_reg.byteCnt > udc_pkg::BYTES_PER_WORD) ?
                    (r_reg.byteCnt - udc_pkg::BYTES_PER_WORD) : udc_pkg::ZERO_WORD; // [RL23]

  always_comb begin
    logic enSet;
    logic enClr;
    logic stopNow;
    logic endEdge;
    logic [15:0] newCfg;
    enSet = 1'b0;
    enClr = 1'b0;
    stopNow = 1'b0;
    endEdge = endSync & ~r_reg.prevEnd;
    newCfg = r_reg.dmaCfg;
    r_next = r_reg;
    r_next.rdTake = 1'b0;
    r_next.push = 1'b0;
    r_next.discard = 1'b0;
    r_next.sendNow = 1'b0;
    r_next.endEvt = 1'b0;
    r_next.exec = 1'b0;
    r_next.rdData = udc_pkg::ZERO_WORD;
    r_next.prevStrobe = strobeActive;
    r_next.prevEnd = endSync;
    if (strobeActive) begin
      r_next.capData = busSync;
    end else begin
      // Hold the outgoing word steady for the whole strobe
      r_next.busOut = epRdWord;
    end

    // Read data phase
    if (regRd && !commandSelectLine) begin
      if (inGroup(r_reg.cmd, udc_pkg::CMD_EPCFG_RD)) begin
        r_next.rdData = r_reg.epCfg[r_reg.cmd[3:0]]; // [RL20]
      end else begin
        case (r_reg.cmd)
          udc_pkg::CMD_HWCFG_RD: r_next.rdData = r_reg.hwCfg; // [RL14]
          udc_pkg::CMD_DMACFG_RD: r_next.rdData = r_reg.dmaCfg;
          udc_pkg::CMD_DMACNT_RD: r_next.rdData = r_reg.dmaCount;
          default: r_next.rdData = udc_pkg::ZERO_WORD;
        endcase
      end
    end

    // Command and write data phases
    if (regWr && commandSelectLine) begin
      r_next.cmd = regWrData[7:0]; // [RL13] [RL15]
      if (!(inGroup(regWrData[7:0], udc_pkg::CMD_EPCFG_WR) ||
            inGroup(regWrData[7:0], udc_pkg::CMD_EPCFG_RD) ||
            regWrData[7:0] == udc_pkg::CMD_HWCFG_WR ||
            regWrData[7:0] == udc_pkg::CMD_HWCFG_RD ||
            regWrData[7:0] == udc_pkg::CMD_DMACFG_WR ||
            regWrData[7:0] == udc_pkg::CMD_DMACFG_RD ||
            regWrData[7:0] == udc_pkg::CMD_DMACNT_WR ||
            regWrData[7:0] == udc_pkg::CMD_DMACNT_RD)) begin
        r_next.exec = 1'b1; // [RL13]
      end
    end else if (regWr) begin
      if (inGroup(r_reg.cmd, udc_pkg::CMD_EPCFG_WR)) begin
        r_next.epCfg[r_reg.cmd[3:0]] = regWrData; // [RL20]
      end else begin
        case (r_reg.cmd)
          udc_pkg::CMD_HWCFG_WR: r_next.hwCfg = regWrData; // [RL14]
          udc_pkg::CMD_DMACNT_WR: r_next.dmaCount = regWrData; // [RL6]
          udc_pkg::CMD_DMACFG_WR: begin
            newCfg = regWrData;
            r_next.dmaCfg = regWrData;
            enSet = regWrData[udc_pkg::DMACFG_ENABLE_BIT];
            enClr = !regWrData[udc_pkg::DMACFG_ENABLE_BIT];
          end
          default: r_next.cmd = r_reg.cmd;
        endcase
      end
    end

    // Word transfer bookkeeping
    if (wordEnd) begin
      r_next.byteCnt = cntAfter; // [RL23]
      r_next.burstIdx = r_reg.burstIdx + 4'h1;
      if (!r_reg.dmaCfg[udc_pkg::DMACFG_BURST_BIT] || r_reg.burstIdx == LAST_BURST) begin
        r_next.gap = 1'b1; // [RL22]
        r_next.burstIdx = 4'h0;
      end
      if (dirIn) begin
        r_next.wrWord = r_reg.capData;
        // A single remaining byte leaves the high lane unsent
        r_next.wrByteEn = (r_reg.byteCnt == udc_pkg::ONE_BYTE) ? 2'b01 : 2'b11; // [RL17]
        r_next.push = 1'b1;
        r_next.pktBytes = r_reg.pktBytes +
                          ((r_reg.byteCnt == udc_pkg::ONE_BYTE) ? udc_pkg::ONE_BYTE :
                           udc_pkg::BYTES_PER_WORD); // [RL19]
      end else begin
        r_next.rdTake = 1'b1;
      end
    end else if (r_reg.gap && !ackSync) begin
      r_next.gap = 1'b0;
    end

    case (r_reg.state)
      udc_pkg::ST_IDLE: begin
        if (enSet) begin
          r_next.state = udc_pkg::ST_RUN;
        end
      end
      udc_pkg::ST_RUN: begin
        if (endEdge) begin
          stopNow = 1'b1; // [RL3] [RL11]
          r_next.discard = !dirIn; // [RL4]
          r_next.sendNow = dirIn; // [RL5]
        end else if (wordEnd && cntAfter == udc_pkg::ZERO_WORD &&
                     r_reg.dmaCfg[udc_pkg::DMACFG_CNT_STOP_BIT]) begin
          stopNow = 1'b1; // [RL6] [RL7]
          r_next.sendNow = dirIn && (isIso || epBufPartial); // [RL9]
        end else if (r_reg.shortPend && !epDataReady && !strobeActive) begin
          stopNow = 1'b1; // [RL8] [RL3]
        end else if (isIso && usbEndOfPacket) begin
          stopNow = 1'b1; // [RL11]
        end
        if (stopNow) begin
          r_next.state = udc_pkg::ST_DONE; // [RL24]
          r_next.endEvt = 1'b1;
        end
      end
      udc_pkg::ST_DONE: begin
        if (enSet) begin
          r_next.state = udc_pkg::ST_RUN; // [RL24]
        end
      end
      default: r_next.state = udc_pkg::ST_IDLE;
    endcase

    // Enable clear wins and raises no end event
    if (enClr) begin
      r_next.state = udc_pkg::ST_IDLE; // [RL10] [RL3]
      r_next.endEvt = 1'b0;
      r_next.discard = 1'b0;
      r_next.sendNow = 1'b0;
    end
    // Gap is left alone here; it clears itself once acknowledge is idle
    if (enSet) begin
      r_next.byteCnt = r_reg.dmaCount; // [RL6]
      r_next.shortPend = 1'b0;
      r_next.burstIdx = 4'h0;
      r_next.pktBytes = udc_pkg::ZERO_WORD;
    end
    // Length stays visible while the send pulse stands, then restarts
    if (r_reg.sendNow) begin
      r_next.pktBytes = udc_pkg::ZERO_WORD; // [RL19]
    end
    // Short packet arrives; its bytes drain before the stop, and the report wins
    if (r_reg.state == udc_pkg::ST_RUN && epShortRx && !dirIn && !isIso &&
        r_reg.dmaCfg[udc_pkg::DMACFG_SHORT_STOP_BIT]) begin
      r_next.shortPend = 1'b1; // [RL8]
    end
    if (newCfg != r_reg.dmaCfg && !enSet && !enClr) begin
      r_next.dmaCfg = newCfg;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg.state <= udc_pkg::ST_IDLE;
      r_reg.hwCfg <= udc_pkg::HWCFG_RESET;
      r_reg.dmaCfg <= udc_pkg::DMACFG_RESET;
      r_reg.dmaCount <= udc_pkg::DMACNT_RESET;
      r_reg.byteCnt <= udc_pkg::ZERO_WORD;
      r_reg.epCfg <= {udc_pkg::NUM_EP{udc_pkg::EPCFG_RESET}};
      r_reg.cmd <= udc_pkg::CMD_NONE;
      r_reg.rdData <= udc_pkg::ZERO_WORD;
      r_reg.busOut <= udc_pkg::ZERO_WORD;
      r_reg.capData <= udc_pkg::ZERO_WORD;
      r_reg.wrWord <= udc_pkg::ZERO_WORD;
      r_reg.wrByteEn <= 2'b00;
      r_reg.pktBytes <= udc_pkg::ZERO_WORD;
      r_reg.burstIdx <= 4'h0;
      r_reg.gap <= 1'b0;
      r_reg.prevStrobe <= 1'b0;
      r_reg.prevEnd <= 1'b0;
      r_reg.shortPend <= 1'b0;
      r_reg.rdTake <= 1'b0;
      r_reg.push <= 1'b0;
      r_reg.discard <= 1'b0;
      r_reg.sendNow <= 1'b0;
      r_reg.endEvt <= 1'b0;
      r_reg.exec <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Request relies on the controller acknowledging only while it is high
  // A pending short packet keeps requesting until the buffer runs dry
  assign devDmaRequest = (r_reg.state == udc_pkg::ST_RUN) && epDataReady &&
                         !r_reg.gap; // [RL22] [RL24] [RL25] [RL8]
  // Enable follows the synchronised strobe, so it trails the pin by two cycles
  assign dmaBusOe = strobeActive && !dirIn;
  assign dmaBusOut = r_reg.busOut;
  assign regRdData = r_reg.rdData;
  assign dmaEndpoint = epIdx;
  assign dmaDirIn = dirIn;
  assign epRdTake = r_reg.rdTake;
  assign epWrWord = r_reg.wrWord;
  assign epWrByteEn = r_reg.wrByteEn;
  assign epWrPush = r_reg.push;
  assign pktByteCount = r_reg.pktBytes;
  assign epDiscard = r_reg.discard;
  assign epSendNow = r_reg.sendNow;
  assign dmaBusy = (r_reg.state == udc_pkg::ST_RUN);
  assign dmaEndEvent = r_reg.endEvt;
  assign cmdCode = r_reg.cmd;
  assign cmdExec = r_reg.exec;

endmodule

// file: rtl/udc_pkg.sv
/*
  Shared constants for the device-controller DMA engine and command port:
  command codes, configuration bit positions, reset values and state codes.
  Assumes a single 16-bit microprocessor port and 16-bit DMA words.
*/
package udc_pkg;

  // Command codes, low byte of a command-phase write
  localparam logic [7:0] CMD_EPCFG_WR = 8'h20;
  localparam logic [7:0] CMD_EPCFG_RD = 8'h30;
  localparam logic [7:0] CMD_HWCFG_WR = 8'hBA;
  localparam logic [7:0] CMD_HWCFG_RD = 8'hBB;
  localparam logic [7:0] CMD_DMACFG_WR = 8'hF0;
  localparam logic [7:0] CMD_DMACFG_RD = 8'hF1;
  localparam logic [7:0] CMD_DMACNT_WR = 8'hF2;
  localparam logic [7:0] CMD_DMACNT_RD = 8'hF3;
  localparam logic [7:0] CMD_NONE = 8'h00;

  // hardware_config fields
  localparam int HW_ACK_ONLY_BIT = 8;

  // dma_config fields
  localparam int DMACFG_ENABLE_BIT = 0;
  localparam int DMACFG_CNT_STOP_BIT = 1;
  localparam int DMACFG_SHORT_STOP_BIT = 2;
  localparam int DMACFG_BURST_BIT = 3;
  localparam int DMACFG_EP_LSB = 4;

  // endpoint_config fields
  localparam int EPCFG_DIR_IN_BIT = 0;
  localparam int EPCFG_ISO_BIT = 1;

  // Reset values
  localparam logic [15:0] HWCFG_RESET = 16'h0000;
  localparam logic [15:0] DMACFG_RESET = 16'h0000;
  localparam logic [15:0] DMACNT_RESET = 16'h0000;
  localparam logic [15:0] EPCFG_RESET = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // Bytes moved by one DMA word
  localparam logic [15:0] BYTES_PER_WORD = 16'h0002;
  localparam logic [15:0] ONE_BYTE = 16'h0001;

  // Number of endpoint configuration words
  localparam int NUM_EP = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } udc_state_t;

endpackage

// file: rtl/udc_sync.sv
/*
  Two-stage synchroniser for a bundle of level signals.
  Assumes each bit is a level that stays put for several clock cycles.
*/
`timescale 1ns/1ps
module udc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1Reg;

  // Stage one feeds only stage two
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1Reg <= INIT;
      syncOut <= INIT;
    end else begin
      stage1Reg <= asyncIn;
      syncOut <= stage1Reg;
    end
  end

endmodule
